/* hw/rzol_pkg.sv */
// rzol_pkg: constants, register map and carrier types of the resizer output line address generator
`default_nettype none

package rzol_pkg;

    // bus geometry
    localparam int unsigned RZOL_ADDR_W   = 8;
    localparam int unsigned RZOL_DATA_W   = 32;
    localparam int unsigned RZOL_PLANES   = 2;
    localparam int unsigned RZOL_LUMA     = 0;
    localparam int unsigned RZOL_CHROMA   = 1;

    // per-plane bank: byte address = bank + 4 * register select
    localparam logic [7:0] RZOL_LUMA_BANK     = 8'h00;
    localparam logic [7:0] RZOL_CHROMA_BANK   = 8'h20;
    localparam logic [2:0] RZOL_SEL_BASE_HI   = 3'h0;
    localparam logic [2:0] RZOL_SEL_BASE_LO   = 3'h1;
    localparam logic [2:0] RZOL_SEL_START_HI  = 3'h2;
    localparam logic [2:0] RZOL_SEL_START_LO  = 3'h3;
    localparam logic [2:0] RZOL_SEL_PITCH     = 3'h4;
    localparam logic [2:0] RZOL_SEL_START_LN  = 3'h5;
    localparam logic [2:0] RZOL_SEL_CAPACITY  = 3'h6;
    localparam logic [2:0] RZOL_SEL_CUR_ADDR  = 3'h7;

    // shared registers
    localparam logic [7:0] RZOL_CTRL_ADDR     = 8'h40;
    localparam logic [7:0] RZOL_POS_ADDR      = 8'h44;

    // control register fields
    localparam int unsigned RZOL_CTRL_RGB_EN  = 0;
    localparam int unsigned RZOL_CTRL_RGB_W   = 1;

    // position register fields
    localparam int unsigned RZOL_POS_LUMA_LSB   = 0;
    localparam int unsigned RZOL_POS_CHROMA_LSB = 16;

    // field widths and masks
    localparam int unsigned RZOL_LINE_W       = 13;
    localparam logic [15:0] RZOL_PITCH_KEEP   = 16'hffe0;

    // values after reset
    localparam logic [15:0] RZOL_ADDR_RST     = 16'h0000;
    localparam logic [15:0] RZOL_PITCH_RST    = 16'h0000;
    localparam logic [12:0] RZOL_START_LN_RST = 13'h0000;
    localparam logic [12:0] RZOL_CAP_RST      = 13'h1fff;

    // AXI responses
    localparam logic [1:0] RZOL_RESP_OKAY     = 2'b00;
    localparam logic [1:0] RZOL_RESP_SLVERR   = 2'b10;

    typedef struct packed {
        logic [15:0] base_hi;
        logic [15:0] base_lo;
        logic [15:0] start_hi;
        logic [15:0] start_lo;
        logic [15:0] pitch;
        logic [12:0] start_line;
        logic [12:0] capacity;
    } rzol_plane_cfg_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [12:0] line_pos;
        logic        wrap;
    } rzol_plane_out_t;

endpackage : rzol_pkg

`default_nettype wire

/* hw/rzol_plane_addr.sv */
// rzol_plane_addr: line address walker for one output plane
`default_nettype none

module rzol_plane_addr (
    input  wire logic                     mclk_i,
    input  wire logic                     srst_i,
    input  wire rzol_pkg::rzol_plane_cfg_t cfg_i,
    input  wire logic [15:0]              pitch_i,
    input  wire logic                     frame_start_i,
    input  wire logic                     line_done_i,
    output var  rzol_pkg::rzol_plane_out_t out_o
);
    import rzol_pkg::*;

    logic [31:0] addr_ff;
    logic [12:0] pos_ff;
    logic        wrap_ff;
    logic        at_end;

    // a start line past the capacity also wraps on its first advance
    assign at_end = (pos_ff >= cfg_i.capacity);

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            addr_ff <= 32'h0000_0000;
            pos_ff  <= RZOL_START_LN_RST;
            wrap_ff <= 1'b0;
        end
        else if (frame_start_i)
        begin
            addr_ff <= {cfg_i.start_hi, cfg_i.start_lo};
            pos_ff  <= cfg_i.start_line;
            wrap_ff <= 1'b0;
        end
        else if (line_done_i)
        begin
            if (at_end)
            begin
                addr_ff <= {cfg_i.base_hi, cfg_i.base_lo};
                pos_ff  <= 13'h0000;
                wrap_ff <= 1'b1;
            end
            else
            begin
                // running sum instead of a multiplier: same result, one adder
                addr_ff <= addr_ff + {16'h0000, pitch_i};
                pos_ff  <= pos_ff + 13'h0001;
                wrap_ff <= 1'b0;
            end
        end
        else
        begin
            wrap_ff <= 1'b0;
        end
    end

    assign out_o = '{addr: addr_ff, line_pos: pos_ff, wrap: wrap_ff};

endmodule : rzol_plane_addr

`default_nettype wire

/* hw/rzol_out_addr_gen.sv */
// rzol_out_addr_gen: output line address generator with AXI4-Lite register file
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`default_nettype none

module rzol_out_addr_gen (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // resizer datapath side
    input  wire logic        frame_start_i,
    input  wire logic        luma_line_done_i,
    input  wire logic        chroma_line_done_i,
    input  wire logic [12:0] line_pixels_i,
    output logic [31:0]      luma_addr_o,
    output logic [31:0]      chroma_addr_o,
    output logic [12:0]      luma_line_pos_o,
    output logic [12:0]      chroma_line_pos_o,
    output logic             luma_wrap_o,
    output logic             chroma_wrap_o,
    output logic             rgb_output_enable_o,
    output logic             rgb_width_select_o
);
    import rzol_pkg::*;

    rzol_plane_cfg_t cfg_ff [RZOL_PLANES];
    rzol_plane_out_t plane_out [RZOL_PLANES];
    logic [1:0]      line_done;

    logic        rgb_en_ff;
    logic        rgb_width_ff;

    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        do_write;
    logic        nxt_aw_held;
    logic        nxt_w_held;
    logic        nxt_bvalid;
    logic        nxt_rvalid;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [32:0] wr_old;
    logic [31:0] wr_mask;
    logic [31:0] wr_word;
    logic [32:0] rd_word;
    logic [15:0] rgb_pitch;
    logic [15:0] eff_pitch [RZOL_PLANES];

    // returns {hit, data}; unmapped words and reserved bits give zero
    function automatic logic [32:0] reg_read(input logic [7:0] a);
        logic [32:0]     r;
        rzol_plane_cfg_t c;
        r = 33'h0_0000_0000;
        c = cfg_ff[a[5]];
        if (a[7:6] == 2'b00)
        begin
            unique case (a[4:2])
                RZOL_SEL_BASE_HI:  r = {1'b1, 16'h0000, c.base_hi};
                RZOL_SEL_BASE_LO:  r = {1'b1, 16'h0000, c.base_lo};
                RZOL_SEL_START_HI: r = {1'b1, 16'h0000, c.start_hi};
                RZOL_SEL_START_LO: r = {1'b1, 16'h0000, c.start_lo};
                RZOL_SEL_PITCH:    r = {1'b1, 16'h0000, c.pitch};
                RZOL_SEL_START_LN: r = {1'b1, 19'h00000, c.start_line};
                RZOL_SEL_CAPACITY: r = {1'b1, 19'h00000, c.capacity};
                RZOL_SEL_CUR_ADDR: r = {1'b1, plane_out[a[5]].addr};
            endcase
        end
        else if (a[7:2] == RZOL_CTRL_ADDR[7:2])
        begin
            r = {1'b1, 30'h0000_0000, rgb_width_ff, rgb_en_ff};
        end
        else if (a[7:2] == RZOL_POS_ADDR[7:2])
        begin
            r = {1'b1, 3'h0, plane_out[RZOL_CHROMA].line_pos,
                 3'h0, plane_out[RZOL_LUMA].line_pos};
        end
        return r;
    endfunction : reg_read

    // write channel: address and data are caught in either order
    assign aw_take  = s_axi_awvalid_i & awready_ff;
    assign w_take   = s_axi_wvalid_i & wready_ff;
    assign wr_addr  = aw_held_ff ? awaddr_ff : s_axi_awaddr_i;
    assign wr_data  = w_held_ff ? wdata_ff : s_axi_wdata_i;
    assign wr_strb  = w_held_ff ? wstrb_ff : s_axi_wstrb_i;
    assign do_write = (aw_held_ff | aw_take) & (w_held_ff | w_take);

    always_comb
    begin
        nxt_aw_held = (aw_held_ff | aw_take) & ~do_write;
        nxt_w_held  = (w_held_ff | w_take) & ~do_write;
        nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready_i);
        nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready_i);
    end

    // byte lanes merge into the current word so untouched lanes keep their value
    always_comb
    begin
        wr_old  = reg_read(wr_addr);
        rd_word = reg_read(s_axi_araddr_i);
    end
    assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_word = (wr_old[31:0] & ~wr_mask) | (wr_data & wr_mask);

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            if (aw_take)
            begin
                awaddr_ff <= s_axi_awaddr_i;
            end
            if (w_take)
            begin
                wdata_ff <= s_axi_wdata_i;
                wstrb_ff <= s_axi_wstrb_i;
            end
            // no new address or data while a response is owed
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RZOL_RESP_OKAY;
        end
        else
        begin
            bvalid_ff <= nxt_bvalid;
            if (do_write)
            begin
                bresp_ff <= wr_old[32] ? RZOL_RESP_OKAY : RZOL_RESP_SLVERR;
            end
        end
    end

    // read channel: one cycle from address to data
    assign ar_take = s_axi_arvalid_i & arready_ff;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RZOL_RESP_OKAY;
        end
        else
        begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take)
            begin
                rdata_ff <= rd_word[31:0];
                rresp_ff <= rd_word[32] ? RZOL_RESP_OKAY : RZOL_RESP_SLVERR;
            end
        end
    end

    // mode bits shared by both planes
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            rgb_en_ff    <= 1'b0;
            rgb_width_ff <= 1'b0;
        end
        else if (do_write && wr_addr[7:2] == RZOL_CTRL_ADDR[7:2])
        begin
            rgb_en_ff    <= wr_word[RZOL_CTRL_RGB_EN];
            rgb_width_ff <= wr_word[RZOL_CTRL_RGB_W];
        end
    end

    // RGB lines are packed back to back: 4 bytes per ARGB pixel, 2 per 565 pixel
    always_comb
    begin
        if (rgb_width_ff)
        begin
            rgb_pitch = {2'b00, line_pixels_i, 1'b0};
        end
        else
        begin
            rgb_pitch = {1'b0, line_pixels_i, 2'b00};
        end
    end

    assign line_done = {chroma_line_done_i, luma_line_done_i};

    genvar p;
    generate
        for (p = 0; p < RZOL_PLANES; p++)
        begin : g_plane
            always_ff @(posedge mclk_i)
            begin
                if (srst_i)
                begin
                    cfg_ff[p].base_hi    <= RZOL_ADDR_RST;
                    cfg_ff[p].base_lo    <= RZOL_ADDR_RST;
                    cfg_ff[p].start_hi   <= RZOL_ADDR_RST;
                    cfg_ff[p].start_lo   <= RZOL_ADDR_RST;
                    cfg_ff[p].pitch      <= RZOL_PITCH_RST;
                    cfg_ff[p].start_line <= RZOL_START_LN_RST;
                    cfg_ff[p].capacity   <= RZOL_CAP_RST;
                end
                else if (do_write && wr_addr[7:6] == 2'b00 && wr_addr[5] == 1'(p))
                begin
                    unique case (wr_addr[4:2])
                        RZOL_SEL_BASE_HI:  cfg_ff[p].base_hi    <= wr_word[15:0];
                        RZOL_SEL_BASE_LO:  cfg_ff[p].base_lo    <= wr_word[15:0];
                        RZOL_SEL_START_HI: cfg_ff[p].start_hi   <= wr_word[15:0];
                        RZOL_SEL_START_LO: cfg_ff[p].start_lo   <= wr_word[15:0];
                        RZOL_SEL_PITCH:
                            cfg_ff[p].pitch <= wr_word[15:0] & RZOL_PITCH_KEEP;
                        RZOL_SEL_START_LN: cfg_ff[p].start_line <= wr_word[12:0];
                        RZOL_SEL_CAPACITY: cfg_ff[p].capacity   <= wr_word[12:0];
                        RZOL_SEL_CUR_ADDR: cfg_ff[p].capacity   <= cfg_ff[p].capacity;
                    endcase
                end
            end

            // the programmed pitch is bypassed entirely in RGB mode
            assign eff_pitch[p] = rgb_en_ff ? rgb_pitch : cfg_ff[p].pitch;

            rzol_plane_addr u_plane (
                .mclk_i        (mclk_i),
                .srst_i        (srst_i),
                .cfg_i         (cfg_ff[p]),
                .pitch_i       (eff_pitch[p]),
                .frame_start_i (frame_start_i),
                .line_done_i   (line_done[p]),
                .out_o         (plane_out[p])
            );
        end
    endgenerate

    assign s_axi_awready_o     = awready_ff;
    assign s_axi_wready_o      = wready_ff;
    assign s_axi_bvalid_o      = bvalid_ff;
    assign s_axi_bresp_o       = bresp_ff;
    assign s_axi_arready_o     = arready_ff;
    assign s_axi_rvalid_o      = rvalid_ff;
    assign s_axi_rdata_o       = rdata_ff;
    assign s_axi_rresp_o       = rresp_ff;
    assign luma_addr_o         = plane_out[RZOL_LUMA].addr;
    assign chroma_addr_o       = plane_out[RZOL_CHROMA].addr;
    assign luma_line_pos_o     = plane_out[RZOL_LUMA].line_pos;
    assign chroma_line_pos_o   = plane_out[RZOL_CHROMA].line_pos;
    assign luma_wrap_o         = plane_out[RZOL_LUMA].wrap;
    assign chroma_wrap_o       = plane_out[RZOL_CHROMA].wrap;
    assign rgb_output_enable_o = rgb_en_ff;
    assign rgb_width_select_o  = rgb_width_ff;

endmodule : rzol_out_addr_gen

`default_nettype wire

/* testbench/rzol_out_addr_gen_asserts.sv */
// rzol_out_addr_gen_asserts: port-level checks of the line address generator
`default_nettype none

module rzol_out_addr_gen_asserts (
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        frame_start_i,
    input wire logic        luma_line_done_i,
    input wire logic        chroma_line_done_i,
    input wire logic [31:0] luma_addr_o,
    input wire logic [31:0] chroma_addr_o,
    input wire logic [12:0] luma_line_pos_o,
    input wire logic [12:0] chroma_line_pos_o,
    input wire logic        luma_wrap_o,
    input wire logic        chroma_wrap_o,
    input wire logic        rgb_output_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    a_frame_no_wrap: assert property (frame_start_i |=> !luma_wrap_o && !chroma_wrap_o)
        else $error("wrap pulse after frame start");
    a_luma_advance: assert property (luma_line_done_i && !frame_start_i |=>
        luma_line_pos_o == $past(luma_line_pos_o) + 13'h1 || luma_wrap_o)
        else $error("luma position did not advance by one");
    a_luma_hold: assert property (!frame_start_i && !luma_line_done_i |=>
        $stable(luma_addr_o) && $stable(luma_line_pos_o))
        else $error("luma state moved without a strobe");
    a_chroma_hold: assert property (!frame_start_i && !chroma_line_done_i |=>
        $stable(chroma_addr_o) && $stable(chroma_line_pos_o))
        else $error("chroma state moved without a strobe");
    // rgb mode strides by the pixel count, not by the 32-byte pitch
    a_pitch_align: assert property (luma_line_done_i && !frame_start_i && !rgb_output_enable_o
        |=> luma_wrap_o || luma_addr_o[4:0] == $past(luma_addr_o[4:0]))
        else $error("luma stride not a multiple of 32");
    a_wrap_zero: assert property (luma_wrap_o || chroma_wrap_o |->
        (!luma_wrap_o || luma_line_pos_o == 13'h0) && (!chroma_wrap_o || chroma_line_pos_o == 13'h0))
        else $error("wrap without position zero");
    a_write_resp: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> s_axi_bvalid_o && !s_axi_awready_o)
        else $error("write response missing");
    a_read_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read response missing");

    c_luma_wrap: cover property (luma_wrap_o);
    c_chroma_wrap: cover property (chroma_wrap_o);
    c_rgb_line: cover property (rgb_output_enable_o && luma_line_done_i);

endmodule : rzol_out_addr_gen_asserts

`default_nettype wire

/* testbench/rzol_line_model.sv */
// rzol_line_model: resizer write side, issues frame and line strobes and logs line addresses
`default_nettype none

module rzol_line_model (
    input  wire logic        mclk_i,
    input  wire logic [31:0] luma_addr_i,
    input  wire logic [31:0] chroma_addr_i,
    output var  logic        frame_start_o,
    output var  logic        luma_line_done_o,
    output var  logic        chroma_line_done_o,
    output var  logic [12:0] line_pixels_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] wr_addr_ff [2];

    initial
    begin
        frame_start_o = 1'b0;
        {chroma_line_done_o, luma_line_done_o} = 2'b00;
        line_pixels_o = 13'h0;
    end

    // a line lands at the address presented when its done strobe is taken
    always_ff @(posedge mclk_i)
    begin
        if (luma_line_done_o)
            wr_addr_ff[0] <= luma_addr_i;
        if (chroma_line_done_o)
            wr_addr_ff[1] <= chroma_addr_i;
    end

    task automatic frame(input logic [12:0] px);
        @(posedge mclk_i);
        frame_start_o <= 1'b1;
        line_pixels_o <= px;
        @(posedge mclk_i);
        frame_start_o <= 1'b0;
        @(negedge mclk_i);
    endtask : frame

    task automatic line(input logic c);
        @(posedge mclk_i);
        {chroma_line_done_o, luma_line_done_o} <= c ? 2'b10 : 2'b01;
        @(posedge mclk_i);
        {chroma_line_done_o, luma_line_done_o} <= 2'b00;
        @(negedge mclk_i);
    endtask : line

endmodule : rzol_line_model

`default_nettype wire

/* testbench/test_resizer_output_line_address_gen.sv */
// test_resizer_output_line_address_gen: directed bench for the output line address generator
`default_nettype none

module test_resizer_output_line_address_gen
    import rzol_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_i = 1'b0;
    logic        srst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
    logic        s_axi_rready_i;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i;
    logic [3:0]  s_axi_wstrb_i;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, luma_wrap_o, chroma_wrap_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o, luma_addr_o, chroma_addr_o;
    logic [12:0] luma_line_pos_o, chroma_line_pos_o, line_pixels_i;
    logic        frame_start_i, luma_line_done_i, chroma_line_done_i;
    logic        rgb_output_enable_o, rgb_width_select_o;
    int          errors = 0;
    int          n_tests = 0;

    rzol_out_addr_gen u_dut (.*);

    rzol_line_model u_mem (
        .mclk_i             (mclk_i),
        .luma_addr_i        (luma_addr_o),
        .chroma_addr_i      (chroma_addr_o),
        .frame_start_o      (frame_start_i),
        .luma_line_done_o   (luma_line_done_i),
        .chroma_line_done_o (chroma_line_done_i),
        .line_pixels_o      (line_pixels_i)
    );

    always #2 mclk_i = ~mclk_i;

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic hang;
        errors++;
        $display("Error bus answer expected within 64 cycles seen none");
        print_verdict();
    endtask : hang

    function automatic logic [7:0] ra(input logic [7:0] bk, input logic [2:0] s);
        return bk + {3'b000, s, 2'b00};
    endfunction : ra

    // address and data are offered together; each is dropped at the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw;
        logic       w;
        logic       b;
        logic [1:0] r;
        int         i;
        @(posedge mclk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            @(negedge mclk_i);
            aw = s_axi_awready_o;
            w  = s_axi_wready_o;
            b  = s_axi_bvalid_o;
            r  = s_axi_bresp_o;
            @(posedge mclk_i);
            if (aw === 1'b1)
                s_axi_awvalid_i <= 1'b0;
            if (w === 1'b1)
                s_axi_wvalid_i <= 1'b0;
            if (b === 1'b1)
                break;
        end
        s_axi_bready_i <= 1'b0;
        if (i == 64)
            hang();
        chk("bresp", 32'(er), 32'(r));
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        logic v;
        int   i;
        @(posedge mclk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            @(negedge mclk_i);
            ar = s_axi_arready_o;
            v  = s_axi_rvalid_o;
            d  = s_axi_rdata_o;
            r  = s_axi_rresp_o;
            @(posedge mclk_i);
            if (ar === 1'b1)
                s_axi_arvalid_i <= 1'b0;
            if (v === 1'b1)
                break;
        end
        s_axi_rready_i <= 1'b0;
        if (i == 64)
            hang();
    endtask : rd

    task automatic wk(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, RZOL_RESP_OKAY);
    endtask : wk

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk("rdata", exp, d);
        chk("rresp", 32'(RZOL_RESP_OKAY), 32'(r));
    endtask : rchk

    task automatic cfg(input logic [7:0] bk, input logic [31:0] base, input logic [31:0] start,
                       input logic [15:0] pitch, input logic [12:0] sl, input logic [12:0] cap);
        logic [31:0] v [7];
        v = '{32'(base[31:16]), 32'(base[15:0]), 32'(start[31:16]), 32'(start[15:0]),
              32'(pitch), 32'(sl), 32'(cap)};
        for (int s = 0; s < 7; s++)
            wk(ra(bk, 3'(s)), v[s]);
    endtask : cfg

    // sampled on the falling edge after a strobe, while the one-cycle wrap pulse stands
    task automatic look(input logic c, input logic [31:0] ea, input logic [12:0] ep, input logic ew);
        chk("addr", ea, c ? chroma_addr_o : luma_addr_o);
        chk("pos", 32'(ep), 32'(c ? chroma_line_pos_o : luma_line_pos_o));
        chk("wrap", 32'(ew), 32'(c ? chroma_wrap_o : luma_wrap_o));
    endtask : look

    task automatic t_reset_vals;
        rchk(ra(RZOL_LUMA_BANK, RZOL_SEL_CAPACITY), 32'h0000_1fff);
        rchk(ra(RZOL_CHROMA_BANK, RZOL_SEL_CAPACITY), 32'h0000_1fff);
        rchk(ra(RZOL_CHROMA_BANK, RZOL_SEL_PITCH), 32'h0);
        rchk(RZOL_CTRL_ADDR, 32'h0);
        look(1'b0, 32'h0, 13'h0, 1'b0);
    endtask : t_reset_vals

    task automatic t_fields;
        logic [31:0] d;
        logic [1:0]  r;
        wk(ra(RZOL_LUMA_BANK, RZOL_SEL_PITCH), 32'hffff_ffff);
        rchk(ra(RZOL_LUMA_BANK, RZOL_SEL_PITCH), 32'h0000_ffe0);
        wk(ra(RZOL_CHROMA_BANK, RZOL_SEL_START_LN), 32'hffff_ffff);
        rchk(ra(RZOL_CHROMA_BANK, RZOL_SEL_START_LN), 32'h0000_1fff);
        wk(ra(RZOL_CHROMA_BANK, RZOL_SEL_BASE_HI), 32'habcd_1234);
        rchk(ra(RZOL_CHROMA_BANK, RZOL_SEL_BASE_HI), 32'h0000_1234);
        s_axi_wstrb_i <= 4'h2;
        wk(ra(RZOL_LUMA_BANK, RZOL_SEL_BASE_LO), 32'h1234_5678);
        s_axi_wstrb_i <= 4'hf;
        rchk(ra(RZOL_LUMA_BANK, RZOL_SEL_BASE_LO), 32'h0000_5600);
        wr(8'h80, 32'h1, RZOL_RESP_SLVERR);
        rd(8'h80, d, r);
        chk("rresp", 32'(RZOL_RESP_SLVERR), 32'(r));
        chk("rdata", 32'h0, d);
    endtask : t_fields

    task automatic t_wrap;
        cfg(RZOL_LUMA_BANK, 32'h0010_0000, 32'h0010_0100, 16'h0047, 13'h0, 13'h3);
        cfg(RZOL_CHROMA_BANK, 32'h0020_0000, 32'h0020_0000, 16'h0020, 13'h0, 13'h1fff);
        u_mem.frame(13'h0);
        look(1'b0, 32'h0010_0100, 13'h0, 1'b0);
        for (int k = 1; k <= 4; k++)
        begin
            u_mem.line(1'b0);
            look(1'b0, k == 4 ? 32'h0010_0000 : 32'h0010_0100 + 32'(k) * 32'h40, 13'(k % 4), k == 4);
            chk("line write", 32'h0010_0100 + 32'(k - 1) * 32'h40, u_mem.wr_addr_ff[0]);
        end
        look(1'b1, 32'h0020_0000, 13'h0, 1'b0);
        u_mem.line(1'b0);
        look(1'b0, 32'h0010_0040, 13'h1, 1'b0);
        u_mem.line(1'b1);
        look(1'b1, 32'h0020_0020, 13'h1, 1'b0);
        look(1'b0, 32'h0010_0040, 13'h1, 1'b0);
        rchk(ra(RZOL_LUMA_BANK, RZOL_SEL_CUR_ADDR), 32'h0010_0040);
        rchk(RZOL_POS_ADDR, 32'h0001_0001);
    endtask : t_wrap

    task automatic t_start_line;
        cfg(RZOL_CHROMA_BANK, 32'h0020_0000, 32'h0020_0400, 16'h0020, 13'h5, 13'h6);
        u_mem.frame(13'h0);
        look(1'b1, 32'h0020_0400, 13'h5, 1'b0);
        u_mem.line(1'b1);
        look(1'b1, 32'h0020_0420, 13'h6, 1'b0);
        u_mem.line(1'b1);
        look(1'b1, 32'h0020_0000, 13'h0, 1'b1);
    endtask : t_start_line

    task automatic t_rgb;
        cfg(RZOL_LUMA_BANK, 32'h0030_0000, 32'h0030_0000, 16'h0040, 13'h0, 13'h1ffc);
        for (int m = 0; m < 2; m++)
        begin
            wk(RZOL_CTRL_ADDR, {30'h0, 1'(m), 1'b1});
            rchk(RZOL_CTRL_ADDR, {30'h0, 1'(m), 1'b1});
            chk("rgb enable", 32'h1, 32'(rgb_output_enable_o));
            chk("rgb width", 32'(m), 32'(rgb_width_select_o));
            u_mem.frame(13'd10);
            u_mem.line(1'b0);
            look(1'b0, 32'h0030_0000 + (m == 1 ? 32'd20 : 32'd40), 13'h1, 1'b0);
        end
        wk(RZOL_CTRL_ADDR, 32'h0);
        chk("rgb enable", 32'h0, 32'(rgb_output_enable_o));
    endtask : t_rgb

    initial
    begin
        srst_i <= 1'b1;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} <= 3'h0;
        {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {16'h0, 32'h0, 4'hf};
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_reset_vals();
        t_fields();
        t_wrap();
        t_start_line();
        t_rgb();
        print_verdict();
    end

endmodule : test_resizer_output_line_address_gen

bind rzol_out_addr_gen rzol_out_addr_gen_asserts u_chk (.*);

`default_nettype wire
